// ---- fpa_params.svh ----
// Functional notes
// [RULE_01] 16-bit add saturates to +32767/-32768
// [RULE_02] 16-bit subtract saturates to +32767/-32768
// [RULE_03] scaled product is product shifted right 15
// [RULE_04] rounded product adds 16384 before shifting
// [RULE_05] magnitude saturates most negative to 32767
// [RULE_06] fractional divide truncates, equal gives 32767
// [RULE_07] long product is product shifted left one
// [RULE_08] long add saturates at 32-bit limits
// [RULE_09] long subtract saturates at 32-bit limits
// [RULE_10] short-to-long sign extends, long-to-short truncates
// [RULE_11] constants in long ops are sign extended
// [RULE_12] left shift, negative count shifts right
// [RULE_13] right shift, negative count shifts left
// [RULE_14] only valid sample bits affect results
// [RULE_15] frames of 160, sub-segments of 40
// [RULE_16] parameters per frame and per sub-segment
// [RULE_17] source sends sign, twelve valid, three spare
// [RULE_18] downscale: shift right 3, left 2
// [RULE_19] difference with previous sample, shifted 15
// [RULE_20] recursive 31x16 split with 32735 coefficient
// [RULE_21] output is rounded memory shifted right 15
// [RULE_22] filter memories persist, zero after reset
// [RULE_23] homing zeroes both filter memories
// [RULE_24] one sample per handshake, order kept
`ifndef FPA_PARAMS_SVH
`define FPA_PARAMS_SVH
`define FPA_MAX16       16'sh7fff
`define FPA_MIN16       16'sh8000
`define FPA_MAX32       32'sh7fffffff
`define FPA_MIN32       32'sh80000000
`define FPA_RND16       32'sh00004000
`define FPA_RND32       32'sh00004000
`define FPA_HP_COEF     16'sh7fdf
`define FPA_PROD_SHIFT  5'h0f
`define FPA_DIV_STEPS   5'h0f
`define FPA_DS_RIGHT    2'h3
`define FPA_DS_LEFT     2'h2
`define FPA_FRAME_LAST  8'h9f
`define FPA_SUB_LAST    6'h27
`define FPA_SUB_COUNT   2'h3
`endif

// ---- fpa_pkg.sv ----
package fpa_pkg;
  // arithmetic primitive selector
  typedef enum logic [3:0] {
    FPA_ADD, FPA_SUB, FPA_MULT, FPA_MULT_R, FPA_ABS, FPA_DIV,
    FPA_L_MULT, FPA_L_ADD, FPA_L_SUB, FPA_SHL, FPA_SHR, FPA_L_SHL, FPA_L_SHR
  } fpa_op_t;
  typedef logic signed [15:0] fpa_s16_t;
  typedef logic signed [31:0] fpa_s32_t;
endpackage

// ---- fpa_preproc.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpa_params.svh"
module fpa_preproc (
  // clock and reset
  input  wire logic           REF_CLK,
  input  wire logic           RST_N,
  // arithmetic request
  input  wire logic           OP_VALID,
  input  var  fpa_pkg::fpa_op_t OP_CODE,
  input  wire logic [31:0]    OP_A,
  input  wire logic [31:0]    OP_B,
  input  wire logic [5:0]     OP_SHIFT,
  // arithmetic answer
  output logic                RES_VALID,
  output logic [31:0]         RES_DATA,
  // sample input stream
  input  wire logic           IN_VALID,
  input  wire logic           IN_FRAME_START,
  input  wire logic [15:0]    IN_SAMPLE,
  output logic                IN_READY,
  // filtered output stream
  output logic                OUT_VALID,
  output logic                OUT_FRAME_START,
  output logic                OUT_SUBSEG_START,
  output logic [1:0]          OUT_SUBSEG,
  output logic [15:0]         OUT_SAMPLE,
  input  wire logic           OUT_READY,
  // homing command
  input  wire logic           HOME
);
  import fpa_pkg::*;

  // saturating 16-bit add
  function automatic fpa_s16_t f_add(input fpa_s16_t a, input fpa_s16_t b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15])
      f_add = s[16] ? `FPA_MIN16 : `FPA_MAX16; // RULE_01
    else
      f_add = s[15:0];
  endfunction

  // saturating 16-bit subtract
  function automatic fpa_s16_t f_sub(input fpa_s16_t a, input fpa_s16_t b);
    logic signed [16:0] s;
    s = {a[15], a} - {b[15], b};
    if (s[16] != s[15])
      f_sub = s[16] ? `FPA_MIN16 : `FPA_MAX16; // RULE_02
    else
      f_sub = s[15:0];
  endfunction

  // scaled product, truncating or rounding
  function automatic fpa_s16_t f_mult(input fpa_s16_t a, input fpa_s16_t b, input logic rnd);
    fpa_s32_t p;
    p = a * b;
    if (rnd)
      p = p + `FPA_RND16; // RULE_04
    p = p >>> `FPA_PROD_SHIFT; // RULE_03
    // only -32768 squared can leave the 16-bit range
    if (a == `FPA_MIN16 && b == `FPA_MIN16)
      f_mult = `FPA_MAX16; // RULE_03 RULE_04
    else
      f_mult = p[15:0];
  endfunction

  // magnitude with saturation
  function automatic fpa_s16_t f_abs(input fpa_s16_t a);
    if (a == `FPA_MIN16)
      f_abs = `FPA_MAX16; // RULE_05
    else
      f_abs = a[15] ? -a : a;
  endfunction

  // fractional divide, restoring, one bit per step
  function automatic fpa_s16_t f_div(input fpa_s16_t num, input fpa_s16_t den);
    logic [16:0] rem;
    logic [15:0] q;
    rem = {1'b0, num};
    q = 16'h0000;
    // callers guarantee 0 < num <= den; other inputs give no defined value
    for (int k = 0; k < `FPA_DIV_STEPS; k++)
    begin
      q = {q[14:0], 1'b0};
      rem = {rem[15:0], 1'b0};
      if (rem >= {1'b0, den})
      begin
        rem = rem - {1'b0, den};
        q = q + 16'h0001;
      end
    end
    f_div = q; // RULE_06
  endfunction

  // long doubled product
  function automatic fpa_s32_t f_lmult(input fpa_s16_t a, input fpa_s16_t b);
    fpa_s32_t p;
    p = a * b;
    f_lmult = p <<< 1; // RULE_07
  endfunction

  // saturating long add or subtract
  function automatic fpa_s32_t f_laddsub(input fpa_s32_t a, input fpa_s32_t b, input logic sub);
    logic signed [32:0] s;
    s = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
    if (s[32] != s[31])
      f_laddsub = s[32] ? `FPA_MIN32 : `FPA_MAX32; // RULE_08 RULE_09
    else
      f_laddsub = s[31:0];
  endfunction

  // 16-bit shift, direction flips on negative count
  function automatic fpa_s16_t f_sh16(input fpa_s16_t a, input logic signed [5:0] n, input logic left);
    logic [5:0] m;
    m = n[5] ? 6'(-n) : n;
    if (left ^ n[5])
      f_sh16 = a <<< m; // RULE_12 RULE_13
    else
      f_sh16 = a >>> m; // RULE_12 RULE_13
  endfunction

  // 32-bit shift, direction flips on negative count
  function automatic fpa_s32_t f_sh32(input fpa_s32_t a, input logic signed [5:0] n, input logic left);
    logic [5:0] m;
    m = n[5] ? 6'(-n) : n;
    if (left ^ n[5])
      f_sh32 = a <<< m; // RULE_12 RULE_13
    else
      f_sh32 = a >>> m; // RULE_12 RULE_13
  endfunction

  // short-to-long deposit
  function automatic fpa_s32_t f_ext(input fpa_s16_t a);
    f_ext = {{16{a[15]}}, a}; // RULE_10
  endfunction

  // operand views of the request
  fpa_s16_t   op_a16;        // low half of first operand
  fpa_s16_t   op_b16;        // low half of second operand
  fpa_s32_t   next_res;      // answer before the register
  assign op_a16 = OP_A[15:0]; // RULE_10
  assign op_b16 = OP_B[15:0]; // RULE_10

  // primitive selector, short results widened on the bus
  always_comb
  begin
    next_res = 32'sh00000000;
    case (OP_CODE)
      FPA_ADD:    next_res = f_ext(f_add(op_a16, op_b16));
      FPA_SUB:    next_res = f_ext(f_sub(op_a16, op_b16));
      FPA_MULT:   next_res = f_ext(f_mult(op_a16, op_b16, 1'b0));
      FPA_MULT_R: next_res = f_ext(f_mult(op_a16, op_b16, 1'b1));
      FPA_ABS:    next_res = f_ext(f_abs(op_a16));
      FPA_DIV:    next_res = f_ext(f_div(op_a16, op_b16));
      FPA_L_MULT: next_res = f_lmult(op_a16, op_b16);
      FPA_L_ADD:  next_res = f_laddsub(OP_A, OP_B, 1'b0);
      FPA_L_SUB:  next_res = f_laddsub(OP_A, OP_B, 1'b1);
      FPA_SHL:    next_res = f_ext(f_sh16(op_a16, OP_SHIFT, 1'b1));
      FPA_SHR:    next_res = f_ext(f_sh16(op_a16, OP_SHIFT, 1'b0));
      FPA_L_SHL:  next_res = f_sh32(OP_A, OP_SHIFT, 1'b1);
      FPA_L_SHR:  next_res = f_sh32(OP_A, OP_SHIFT, 1'b0);
      default:    next_res = 32'sh00000000;
    endcase
  end

  // arithmetic answer register, one cycle behind the request
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RES_VALID <= 1'b0;
      RES_DATA  <= 32'h00000000;
    end
    else
    begin
      RES_VALID <= OP_VALID;
      if (OP_VALID)
        RES_DATA <= next_res;
    end
  end

  // filter state
  fpa_s16_t   prev_input_memory;       // last downscaled sample
  fpa_s32_t   recursive_filter_memory; // long recursive memory
  logic [7:0] frame_pos;               // sample index in frame
  logic [5:0] sub_pos;                 // sample index in sub-segment
  logic [1:0] sub_idx;                 // current sub-segment
  logic       accept;                  // handshake taken this cycle
  logic       next_out_valid;          // output slot occupied next cycle

  // per-sample datapath
  fpa_s16_t   so;          // downscaled sample
  fpa_s16_t   s1;          // non-recursive difference
  fpa_s16_t   msp;         // memory high part
  fpa_s16_t   lsp;         // memory low part, truncated
  fpa_s16_t   temp;        // rounded low-part product
  fpa_s32_t   l_s2;        // accumulator
  fpa_s32_t   next_mem;    // updated recursive memory
  fpa_s16_t   sof;         // compensated sample
  fpa_s32_t   msp_sh;      // high part moved back up
  fpa_s32_t   l_mem_work;  // memory minus high part

  always_comb
  begin
    // low three bits drop out here, so spare bits never reach the filter
    so = ($signed(IN_SAMPLE) >>> `FPA_DS_RIGHT) <<< `FPA_DS_LEFT; // RULE_18 RULE_14
    s1 = f_sub(so, prev_input_memory); // RULE_19
    l_s2 = f_ext(s1) <<< `FPA_PROD_SHIFT; // RULE_19
    msp = 16'(recursive_filter_memory >>> `FPA_PROD_SHIFT); // RULE_20 RULE_10
    msp_sh = f_ext(msp) <<< `FPA_PROD_SHIFT;
    l_mem_work = f_laddsub(recursive_filter_memory, msp_sh, 1'b1); // RULE_20
    lsp = l_mem_work[15:0]; // RULE_10
    temp = f_mult(lsp, `FPA_HP_COEF, 1'b1); // RULE_20
    l_s2 = f_laddsub(l_s2, f_ext(temp), 1'b0); // RULE_20 RULE_11
    next_mem = f_laddsub(f_lmult(msp, `FPA_HP_COEF) >>> 1, l_s2, 1'b0); // RULE_20
    l_mem_work = f_laddsub(next_mem, `FPA_RND32, 1'b0) >>> `FPA_PROD_SHIFT; // RULE_21 RULE_11
    sof = l_mem_work[15:0]; // RULE_21
  end

  // handshake: slot must be free, ready is registered so it lags a cycle
  assign accept = IN_VALID && IN_READY; // RULE_24
  assign next_out_valid = accept || (OUT_VALID && !OUT_READY);

  // input ready follows the slot that will be free next cycle
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      IN_READY <= 1'b0;
    else
      IN_READY <= !next_out_valid; // RULE_24
  end

  // filter memories survive across frames; homing wins over a sample
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prev_input_memory       <= 16'sh0000; // RULE_22
      recursive_filter_memory <= 32'sh00000000; // RULE_22
    end
    else if (HOME)
    begin
      prev_input_memory       <= 16'sh0000; // RULE_23
      recursive_filter_memory <= 32'sh00000000; // RULE_23
    end
    else if (accept)
    begin
      prev_input_memory       <= so; // RULE_19
      recursive_filter_memory <= next_mem; // RULE_20 RULE_22
    end
  end

  // frame and sub-segment position, marker resynchronises the count
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      frame_pos <= 8'h00;
      sub_pos   <= 6'h00;
      sub_idx   <= 2'h0;
    end
    else if (accept)
    begin
      if (IN_FRAME_START || frame_pos == `FPA_FRAME_LAST)
      begin
        // a marker restarts at sample one of a fresh frame
        frame_pos <= IN_FRAME_START ? 8'h01 : 8'h00; // RULE_15
        sub_pos   <= IN_FRAME_START ? 6'h01 : 6'h00;
        sub_idx   <= 2'h0;
      end
      else if (sub_pos == `FPA_SUB_LAST)
      begin
        frame_pos <= frame_pos + 8'h01;
        sub_pos   <= 6'h00; // RULE_15
        sub_idx   <= sub_idx + 2'h1; // RULE_16
      end
      else
      begin
        frame_pos <= frame_pos + 8'h01;
        sub_pos   <= sub_pos + 6'h01;
      end
    end
  end

  // output slot, held while the sink stalls
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      OUT_VALID        <= 1'b0;
      OUT_SAMPLE       <= 16'h0000;
      OUT_FRAME_START  <= 1'b0;
      OUT_SUBSEG_START <= 1'b0;
      OUT_SUBSEG       <= 2'h0;
    end
    else
    begin
      OUT_VALID <= next_out_valid; // RULE_24
      if (accept)
      begin
        OUT_SAMPLE       <= sof; // RULE_21 RULE_24
        OUT_FRAME_START  <= IN_FRAME_START || frame_pos == 8'h00; // RULE_15
        // sub-segment tags let the analysis stages emit one parameter set each
        OUT_SUBSEG_START <= IN_FRAME_START || sub_pos == 6'h00; // RULE_16
        OUT_SUBSEG       <= IN_FRAME_START ? 2'h0 : sub_idx; // RULE_16
      end
    end
  end

  // checks on the primitives
  a_add_clamp: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_01
    OP_VALID && OP_CODE == FPA_ADD && op_a16 == 16'sh7fff && op_b16 > 0 |=> RES_DATA == 32'h00007fff)
    else $error("add did not clamp high");
  a_sub_clamp: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_02
    OP_VALID && OP_CODE == FPA_SUB && op_a16 == 16'sh8000 && op_b16 > 0 |=> RES_DATA == 32'hffff8000)
    else $error("sub did not clamp low");
  a_mult_corner: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_03
    OP_VALID && (OP_CODE == FPA_MULT || OP_CODE == FPA_MULT_R) && op_a16 == 16'sh8000
    && op_b16 == 16'sh8000 |=> RES_VALID && RES_DATA == 32'h00007fff)
    else $error("product corner wrong");
  a_abs_corner: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_05
    OP_VALID && OP_CODE == FPA_ABS && op_a16 == 16'sh8000 |=> RES_DATA == 32'h00007fff)
    else $error("abs wrapped");
  a_div_equal: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_06
    OP_VALID && OP_CODE == FPA_DIV && op_a16 > 0 && op_a16 == op_b16 |=> RES_DATA == 32'h00007fff)
    else $error("divide of equals wrong");
  a_lmult_sign: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_07
    OP_VALID && OP_CODE == FPA_L_MULT && op_a16 == 16'sh0001 |=> RES_DATA == 32'($past(f_ext(op_b16)) <<< 1))
    else $error("long product wrong");
  a_ladd_clamp: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_08
    OP_VALID && OP_CODE == FPA_L_ADD && OP_A == 32'h7fffffff && !OP_B[31] && OP_B != 0
    |=> RES_DATA == 32'h7fffffff)
    else $error("long add did not clamp");
  a_shift_flip: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_12
    OP_VALID && OP_CODE == FPA_L_SHL && OP_SHIFT == 6'h3f |=> RES_DATA == ($past(OP_A) >> 1 | ($past(OP_A) & 32'h80000000)))
    else $error("negative left shift not a right shift");

  // checks on the stream
  a_stall_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_24
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_SAMPLE) && !IN_READY)
    else $error("output changed under stall");
  a_accept_out: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_24
    accept |=> OUT_VALID ##0 !IN_READY)
    else $error("accepted sample not presented");
  a_downscale: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_18
    accept && !HOME |=> prev_input_memory == {$past(IN_SAMPLE[15]), $past(IN_SAMPLE[15:3]), 2'b00})
    else $error("downscale wrong");
  a_home_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_23
    HOME |=> prev_input_memory == 16'sh0000 && recursive_filter_memory == 32'sh00000000)
    else $error("homing left state");
  a_frame_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_15
    accept && !IN_FRAME_START && frame_pos == `FPA_FRAME_LAST |=> frame_pos == 8'h00 && sub_idx == 2'h0)
    else $error("frame did not wrap at 160");
  a_zero_in: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_21
    accept && !HOME && prev_input_memory == 0 && recursive_filter_memory == 0 && IN_SAMPLE[15:3] == 0
    |=> OUT_SAMPLE == 16'h0000 ##1 recursive_filter_memory == 0)
    else $error("silent input not silent");
endmodule
`default_nettype wire

// ---- fpa_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// upstream companded-to-linear converter, one word per handshake
module fpa_src_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control and random fill
  input  wire logic        en,
  input  wire logic [15:0] rnd,
  // sample stream
  input  wire logic        ready,
  output logic             valid,
  output logic             first,
  output logic [15:0]      sample
);
  logic [7:0] cnt; // position inside the frame
  // known levels before the first reset edge lands
  initial
  begin
    valid = 1'b0;
    first = 1'b0;
    sample = 16'h0000;
  end
  // offer held until taken; idle lines keep changing so stale data never looks valid
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid <= 1'b0;
      cnt <= 8'h00;
    end
    else
    begin
      if (valid && ready)
        cnt <= (cnt == 8'h9f) ? 8'h00 : cnt + 8'h01;
      if (!valid || ready)
      begin
        valid <= en;
        sample <= rnd;
        first <= (valid && ready) ? (cnt == 8'h9f) : (cnt == 8'h00);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_fixed_point_arith_preproc.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_fixed_point_arith_preproc;
  import fpa_pkg::*;
  localparam longint L = 64'sd2147483648; // long saturation bound
  // last pair: unit first operand, low clamp of the long add, sign fill of a flipped shift
  localparam logic [31:0] AT [7] = '{32'h00007fff, 32'hffff8000, 32'h7fffffff, 32'h80008000, 32'h7fffffff,
                                     32'h80007fff, 32'h80000001};
  localparam logic [31:0] BT [7] = '{32'h00007fff, 32'hffff8000, 32'h7fffffff, 32'h80000001, 32'h80000000,
                                     32'h7fff8000, 32'h80008001};
  // design pins
  logic        REF_CLK, RST_N, OP_VALID, RES_VALID, IN_VALID, IN_FRAME_START, IN_READY, HOME;
  logic        OUT_VALID, OUT_FRAME_START, OUT_SUBSEG_START, OUT_READY;
  fpa_op_t     OP_CODE;
  logic [31:0] OP_A, OP_B, RES_DATA, rng;
  logic [5:0]  OP_SHIFT;
  logic [1:0]  OUT_SUBSEG;
  logic [15:0] IN_SAMPLE, OUT_SAMPLE, src_rnd;
  logic        src_en;
  logic        quiet; // samples carry only spare low bits
  // reference model state
  int          n_errors, tests_run, n_out, k;
  logic [31:0] res_q [$];
  logic [19:0] smp_q [$]; // frame flag, sub flag, sub index, sample
  longint      z1, lz2, so, s1, ls2, msp, lsp;

  always #20 REF_CLK = ~REF_CLK;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic longint t16(input longint v);
    return $signed(v[15:0]);
  endfunction
  function automatic longint t32(input longint v);
    return $signed(v[31:0]);
  endfunction
  function automatic longint sat(input longint v, input longint lim);
    return v > lim - 1 ? lim - 1 : (v < -lim ? -lim : v);
  endfunction
  function automatic longint mr(input longint a, input longint b, input longint r);
    return (a == -32768 && b == -32768) ? 32767 : (a * b + r) >>> 15;
  endfunction
  function automatic longint shf(input longint v, input longint n);
    return n >= 0 ? v << n : v >>> (-n);
  endfunction
  // expected answer of one arithmetic request
  function automatic logic [31:0] op_model(input int op, input logic [31:0] a, input logic [31:0] b,
                                           input logic [5:0] sh);
    longint x, y, p, q, n, r;
    x = $signed(a[15:0]);
    y = $signed(b[15:0]);
    p = $signed(a);
    q = $signed(b);
    n = $signed(sh);
    case (op)
      0: r = sat(x + y, 32768);
      1: r = sat(x - y, 32768);
      2: r = mr(x, y, 0);
      3: r = mr(x, y, 16384);
      4: r = x == -32768 ? 32767 : (x < 0 ? -x : x);
      5: r = x == y ? 32767 : x * 32768 / y;
      6: r = x * y * 2;
      7: r = sat(p + q, L);
      8: r = sat(p - q, L);
      9: r = t16(shf(x, n));
      10: r = t16(shf(x, -n));
      11: r = t32(shf(p, n));
      default: r = t32(shf(p, -n));
    endcase
    return (op < 6 || op == 9 || op == 10) ? 32'(t16(r)) : 32'(r);
  endfunction

  task automatic miss(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_errors++;
    $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
  endtask
  task automatic chk_res(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
      miss("arith result", got, exp);
  endtask
  task automatic chk_out(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp)
      miss("stream output", 32'(got), 32'(exp));
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  fpa_preproc dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_A(OP_A),
    .OP_B(OP_B), .OP_SHIFT(OP_SHIFT), .RES_VALID(RES_VALID), .RES_DATA(RES_DATA), .IN_VALID(IN_VALID),
    .IN_FRAME_START(IN_FRAME_START), .IN_SAMPLE(IN_SAMPLE), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
    .OUT_FRAME_START(OUT_FRAME_START), .OUT_SUBSEG_START(OUT_SUBSEG_START), .OUT_SUBSEG(OUT_SUBSEG),
    .OUT_SAMPLE(OUT_SAMPLE), .OUT_READY(OUT_READY), .HOME(HOME));
  fpa_src_model src_u (.clk(REF_CLK), .rst_n(RST_N), .en(src_en), .rnd(src_rnd), .ready(IN_READY),
    .valid(IN_VALID), .first(IN_FRAME_START), .sample(IN_SAMPLE));

  // scoreboard: answers, filter model on every accept, homing after the accept
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      z1 = 0;
      lz2 = 0;
      k = 0;
      smp_q.delete();
    end
    else
    begin
      if (RES_VALID)
        chk_res(RES_DATA, res_q.size() ? res_q.pop_front() : 'x);
      if (OUT_VALID && OUT_READY)
      begin
        chk_out({OUT_FRAME_START, OUT_SUBSEG_START, OUT_SUBSEG, OUT_SAMPLE},
                smp_q.size() ? smp_q.pop_front() : 'x);
        n_out++;
      end
      if (IN_VALID && IN_READY)
      begin
        so = ($signed(IN_SAMPLE) >>> 3) << 2;
        s1 = sat(so - z1, 32768);
        z1 = so;
        ls2 = s1 << 15;
        msp = t16(lz2 >>> 15);
        lsp = t16(sat(lz2 - (msp << 15), L));
        ls2 = sat(ls2 + mr(lsp, 32735, 16384), L);
        lz2 = sat(msp * 32735 + ls2, L);
        if (IN_FRAME_START)
          k = 0;
        smp_q.push_back({k == 0, k % 40 == 0, 2'(k / 40), 16'(t16(sat(lz2 + 16384, L) >>> 15))});
        k = (k + 1) % 160;
      end
      if (HOME)
      begin
        z1 = 0;
        lz2 = 0;
      end
      rng = xs(rng);
      OUT_READY <= rng[1:0] != 2'h0;
      src_rnd <= quiet ? {13'h0, rng[18:16]} : rng[31:16];
    end
  end

  task automatic do_reset;
    @(posedge REF_CLK) RST_N <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    chk_out(20'({OUT_VALID, IN_READY, RES_VALID, OUT_FRAME_START}), 20'h00000);
    RST_N <= 1'b1;
  endtask
  // every primitive, edge operands first, issued back to back
  task automatic run_ops;
    logic [31:0] a, b;
    logic [5:0]  sh;
    for (int op = 0; op < 13; op++)
      for (int i = 0; i < 24; i++)
      begin
        rng = xs(rng);
        a = i < 7 ? AT[i] : rng;
        rng = xs(rng);
        b = i < 7 ? BT[i] : rng;
        if (op == 5)
        begin
          a = 1 + a[14:0] % 32767;
          b = i == 0 ? a : a + b[14:0] % (32768 - a);
        end
        if (op == 6 && a[15:0] == 16'h8000 && b[15:0] == 16'h8000)
          b = 32'h00000001;
        @(posedge REF_CLK);
        // one count of minus one per primitive, so every shift flips direction at least once
        sh = i == 6 ? 6'h3f : rng[5:0];
        OP_VALID <= 1'b1;
        OP_CODE <= fpa_op_t'(op);
        OP_A <= a;
        OP_B <= b;
        OP_SHIFT <= sh;
        res_q.push_back(op_model(op, a, b, sh));
      end
    @(posedge REF_CLK) OP_VALID <= 1'b0;
    repeat (2) @(posedge REF_CLK);
  endtask
  task automatic wait_out(input int n);
    for (int c = 0; c < 4000 && n_out < n; c++)
      @(posedge REF_CLK);
    if (n_out < n)
    begin
      miss("stream stalled", 32'(n_out), 32'(n));
      tally_and_finish();
    end
  endtask

  initial
  begin
    {REF_CLK, RST_N, OP_VALID, OUT_READY, HOME, src_en} = 6'h00;
    quiet = 1'b0;
    {OP_A, OP_B, OP_SHIFT, src_rnd} = '0;
    OP_CODE = FPA_ADD;
    rng = 32'h2817;
    n_errors = 0;
    tests_run = 0;
    n_out = 0;
    do_reset();
    run_ops();
    src_en <= 1'b1;
    wait_out(200);
    // spare bits only, then home: a silent input must leave the filter silent
    quiet <= 1'b1;
    wait_out(204);
    HOME <= 1'b1;
    @(posedge REF_CLK) HOME <= 1'b0;
    wait_out(240);
    quiet <= 1'b0;
    wait_out(400);
    do_reset();
    wait_out(500);
    src_en <= 1'b0;
    // drain: a stalled sink can hold the last offer for several cycles
    for (int c = 0; c < 60 && (IN_VALID || OUT_VALID || smp_q.size() != 0); c++)
      @(posedge REF_CLK);
    if (IN_VALID || OUT_VALID)
      miss("stream did not drain", 32'(IN_VALID), 32'(OUT_VALID));
    chk_out(20'(smp_q.size() + res_q.size()), 20'h00000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
